// ### src/uppoc_top.sv
`default_nettype none

module uppoc_top #(
  parameter int unsigned NUM_PORTS = uppoc_pkg::NUM_PORTS
) (
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 arst_n,
  // software control, one bit per port
  input  wire logic [NUM_PORTS-1:0] port_power_request,
  input  wire logic [NUM_PORTS-1:0] port_unused,
  input  wire logic [NUM_PORTS-1:0] overcurrent_clear,
  // device connection seen on the data lines, from the usb controller
  input  wire logic [NUM_PORTS-1:0] port_connect_detect,
  // shared open-drain enable / fault lines
  input  wire logic [NUM_PORTS-1:0] port_power_enable_fault_n_i,
  output logic      [NUM_PORTS-1:0] port_power_enable_fault_n_o,
  output logic      [NUM_PORTS-1:0] port_power_enable_fault_n_oe_n,
  // pull-up rail switches
  output logic      [NUM_PORTS-1:0] pullup_rail_en,
  // dual-role sense pins
  input  wire logic                 host_power_detect,
  input  wire logic                 dual_role_id_input,
  // per-port status
  output logic      [NUM_PORTS-1:0] port_power_on,
  output logic      [NUM_PORTS-1:0] port_power_good,
  output logic      [NUM_PORTS-1:0] overcurrent_flag,
  output logic      [NUM_PORTS-1:0] overcurrent_event,
  output logic      [NUM_PORTS*uppoc_pkg::FAULT_CNT_W-1:0] overcurrent_count,
  // role status
  output logic                      role_is_device,
  output logic                      host_power_present
);

  // line drive decode shared by the driver and the power-on status
  function automatic logic holds_line_low(input uppoc_pkg::uppoc_state_t st);
    holds_line_low = (st != uppoc_pkg::UPPOC_ON);
  endfunction

  // saturating increment of a fault count
  function automatic logic [uppoc_pkg::FAULT_CNT_W-1:0] sat_inc(
    input logic [uppoc_pkg::FAULT_CNT_W-1:0] v
  );
    sat_inc = (&v) ? v : v + uppoc_pkg::FAULT_CNT_W'(1);
  endfunction

  // synchronised role pins
  logic id_level;
  logic vbus_level;

  // role id pin, high selects device role on the dual-role port
  uppoc_pin_sense #(
    .RESET_LEVEL (uppoc_pkg::SENSE_RST_LVL)
  ) u_id_sense (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .pin_i    (dual_role_id_input),
    .level_q  (id_level),
    .fall_q   (),
    .rise_q   ()
  );

  // upstream host bus power sense
  uppoc_pin_sense #(
    .RESET_LEVEL (uppoc_pkg::SENSE_RST_LVL)
  ) u_vbus_sense (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .pin_i    (host_power_detect),
    .level_q  (vbus_level),
    .fall_q   (),
    .rise_q   ()
  );

  logic role_dev_q;
  logic host_pwr_q;

  // role outputs; bus power only means something in device role
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      role_dev_q <= 1'b0;
      host_pwr_q <= 1'b0;
    end else begin
      role_dev_q <= id_level;
      host_pwr_q <= id_level & vbus_level;
    end
  end

  assign role_is_device     = role_dev_q;
  assign host_power_present = host_pwr_q;

  // per-port signals
  uppoc_pkg::uppoc_state_t state_q [NUM_PORTS];
  uppoc_pkg::uppoc_state_t state_d [NUM_PORTS];
  logic [uppoc_pkg::HIGH_CNT_W-1:0]  high_cnt_q [NUM_PORTS];
  logic [uppoc_pkg::HIGH_CNT_W-1:0]  high_cnt_d [NUM_PORTS];
  logic [uppoc_pkg::FAULT_CNT_W-1:0] fault_cnt_q [NUM_PORTS];
  logic [NUM_PORTS-1:0] line_level;
  logic [NUM_PORTS-1:0] line_fall;
  logic [NUM_PORTS-1:0] port_go;
  logic [NUM_PORTS-1:0] armed;
  logic [NUM_PORTS-1:0] fault_seen;
  logic [NUM_PORTS-1:0] oe_n_q;
  logic [NUM_PORTS-1:0] rail_q;
  logic [NUM_PORTS-1:0] flag_q;
  logic [NUM_PORTS-1:0] flag_d;
  logic [NUM_PORTS-1:0] event_q;
  logic [NUM_PORTS-1:0] on_q;
  logic [NUM_PORTS-1:0] good_q;

  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port

    // line sense, synchronised before any edge detection
    uppoc_pin_sense #(
      .RESET_LEVEL (uppoc_pkg::LINE_RST_LVL)
    ) u_line_sense (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .pin_i    (port_power_enable_fault_n_i[p]),
      .level_q  (line_level[p]),
      .fall_q   (line_fall[p]),
      .rise_q   ()
    );

    // dual-role port supplies power only in host role; unused ports stay off
    if (p == uppoc_pkg::DUAL_ROLE_PORT) begin : g_dual
      assign port_go[p] = port_power_request[p] & ~port_unused[p] & ~role_dev_q;
    end else begin : g_host
      assign port_go[p] = port_power_request[p] & ~port_unused[p];
    end

    // a fall counts only after the released line has read high for a while
    assign armed[p]      = (high_cnt_q[p] == uppoc_pkg::HIGH_CNT_W'(uppoc_pkg::HIGH_CYCLES));
    assign fault_seen[p] = (state_q[p] == uppoc_pkg::UPPOC_ON) & armed[p] & line_fall[p];

    // high-time counter runs only while the line is released and reads high
    assign high_cnt_d[p] = (state_q[p] != uppoc_pkg::UPPOC_ON) ? '0 :
                           !line_level[p]                       ? '0 :
                           armed[p]                             ? high_cnt_q[p] :
                           high_cnt_q[p] + uppoc_pkg::HIGH_CNT_W'(1);

    // sticky flag; a new fault wins over a clear in the same cycle
    assign flag_d[p] = fault_seen[p] | (flag_q[p] & ~overcurrent_clear[p]);

    // power state transitions
    always_comb begin
      state_d[p] = state_q[p];
      case (state_q[p])
        uppoc_pkg::UPPOC_OFF: begin
          if (port_go[p]) begin
            state_d[p] = uppoc_pkg::UPPOC_WAIT;
          end
        end
        uppoc_pkg::UPPOC_WAIT: begin
          if (!port_go[p]) begin
            state_d[p] = uppoc_pkg::UPPOC_OFF;
          end else if (port_connect_detect[p]) begin
            state_d[p] = uppoc_pkg::UPPOC_ON;
          end
        end
        uppoc_pkg::UPPOC_ON: begin
          if (!port_go[p]) begin
            state_d[p] = uppoc_pkg::UPPOC_OFF;
          end else if (fault_seen[p]) begin
            state_d[p] = uppoc_pkg::UPPOC_FAULT;
          end
        end
        uppoc_pkg::UPPOC_FAULT: begin
          if (!port_power_request[p]) begin
            state_d[p] = uppoc_pkg::UPPOC_OFF;
          end
        end
        default: begin
          state_d[p] = uppoc_pkg::UPPOC_OFF;
        end
      endcase
    end

    // state, high-time counter and fault count
    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        state_q[p]     <= uppoc_pkg::UPPOC_OFF;
        high_cnt_q[p]  <= '0;
        fault_cnt_q[p] <= '0;
      end else begin
        state_q[p]    <= state_d[p];
        high_cnt_q[p] <= high_cnt_d[p];
        if (fault_seen[p]) begin
          fault_cnt_q[p] <= sat_inc(fault_cnt_q[p]);
        end
      end
    end

    // open-drain driver and status registers
    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        oe_n_q[p]  <= uppoc_pkg::OE_DRIVE;
        rail_q[p]  <= uppoc_pkg::RAIL_RST;
        flag_q[p]  <= 1'b0;
        event_q[p] <= 1'b0;
        on_q[p]    <= 1'b0;
        good_q[p]  <= 1'b0;
      end else begin
        oe_n_q[p]  <= holds_line_low(state_d[p]) ? uppoc_pkg::OE_DRIVE : uppoc_pkg::OE_RELEASE;
        rail_q[p]  <= ~port_unused[p];
        flag_q[p]  <= flag_d[p];
        event_q[p] <= fault_seen[p];
        on_q[p]    <= ~holds_line_low(state_d[p]);
        good_q[p]  <= (state_q[p] == uppoc_pkg::UPPOC_ON) & armed[p];
      end
    end

    assign overcurrent_count[p*uppoc_pkg::FAULT_CNT_W +: uppoc_pkg::FAULT_CNT_W] = fault_cnt_q[p];
  end

  // pad value is constant low; only the enable moves (open drain)
  assign port_power_enable_fault_n_o    = {NUM_PORTS{uppoc_pkg::DRIVE_LEVEL}};
  assign port_power_enable_fault_n_oe_n = oe_n_q;
  assign pullup_rail_en                 = rail_q;
  assign port_power_on                  = on_q;
  assign port_power_good                = good_q;
  assign overcurrent_flag               = flag_q;
  assign overcurrent_event              = event_q;

endmodule

`default_nettype wire

// ### src/uppoc_pkg.sv
`default_nettype none

// shared constants and types for the usb port power enable / over-current block
package uppoc_pkg;

  // number of shared enable/fault lines handled by the block
  localparam int unsigned NUM_PORTS     = 5;

  // port that can also act in device role (dual-role port)
  localparam int unsigned DUAL_ROLE_PORT = 0;

  // cycles the released line must read high before a fall counts as a fault
  localparam int unsigned HIGH_CYCLES   = 4;
  localparam int unsigned HIGH_CNT_W    = 3;

  // width of the saturating per-port fault counter
  localparam int unsigned FAULT_CNT_W   = 8;

  // open-drain driver: the pad output is always this level, gated by the enable
  localparam logic        DRIVE_LEVEL   = 1'b0;
  localparam logic        OE_DRIVE      = 1'b0;
  localparam logic        OE_RELEASE    = 1'b1;

  // pin synchroniser reset values; the module holds the lines low through reset
  localparam logic        LINE_RST_LVL  = 1'b0;
  localparam logic        SENSE_RST_LVL = 1'b0;

  // reset value of the pull-up rail enables
  localparam logic        RAIL_RST      = 1'b0;

  // per-port power state
  typedef enum logic [1:0] {
    UPPOC_OFF   = 2'b00,  // line held low, switch disabled
    UPPOC_WAIT  = 2'b01,  // power requested, waiting for a device connection
    UPPOC_ON    = 2'b10,  // line released, switch enabled by the pull-up
    UPPOC_FAULT = 2'b11   // over-current seen, line held low until request drops
  } uppoc_state_t;

endpackage

`default_nettype wire

// ### src/uppoc_pin_sense.sv
`default_nettype none

// three-flop pin synchroniser with agreement filter and edge pulses
module uppoc_pin_sense #(
  parameter logic RESET_LEVEL = 1'b1
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic arst_n,
  // raw pin
  input  wire logic pin_i,
  // filtered level and edges
  output logic      level_q,
  output logic      fall_q,
  output logic      rise_q
);

  logic stage1_q;
  logic stage2_q;
  logic stage3_q;
  logic agree;
  logic level_d;

  // a change is accepted only once the second and third stages agree
  assign agree   = (stage2_q == stage3_q);
  assign level_d = agree ? stage3_q : level_q;

  // synchroniser chain; the first stage feeds the second and nothing else
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1_q <= RESET_LEVEL;
      stage2_q <= RESET_LEVEL;
      stage3_q <= RESET_LEVEL;
    end else begin
      stage1_q <= pin_i;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
    end
  end

  // filtered level and registered one-cycle edge pulses
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      level_q <= RESET_LEVEL;
      fall_q  <= 1'b0;
      rise_q  <= 1'b0;
    end else begin
      level_q <= level_d;
      fall_q  <= level_q & ~level_d;
      rise_q  <= ~level_q & level_d;
    end
  end

endmodule

`default_nettype wire

// ### verif/uppoc_sva.sv
`default_nettype none

// port-level checks on the power enable / over-current block
module uppoc_sva #(
  parameter int unsigned NUM_PORTS = 5
) (
  // clock and reset
  input wire logic                 core_clk,
  input wire logic                 arst_n,
  // control inputs
  input wire logic [NUM_PORTS-1:0] port_unused,
  input wire logic [NUM_PORTS-1:0] overcurrent_clear,
  input wire logic [NUM_PORTS-1:0] port_connect_detect,
  // line driver
  input wire logic [NUM_PORTS-1:0] port_power_enable_fault_n_o,
  input wire logic [NUM_PORTS-1:0] port_power_enable_fault_n_oe_n,
  // status
  input wire logic [NUM_PORTS-1:0] pullup_rail_en,
  input wire logic [NUM_PORTS-1:0] port_power_on,
  input wire logic [NUM_PORTS-1:0] overcurrent_flag,
  input wire logic [NUM_PORTS-1:0] overcurrent_event,
  input wire logic                 role_is_device,
  input wire logic                 host_power_present
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  // short aliases
  wire logic [NUM_PORTS-1:0] oe = port_power_enable_fault_n_oe_n;
  wire logic [NUM_PORTS-1:0] fl = overcurrent_flag;
  wire logic [NUM_PORTS-1:0] ev = overcurrent_event;

  // line driving and release
  a_od_low: assert property (port_power_enable_fault_n_o == '0)
    else $error("drive value not low");
  a_on_release: assert property (port_power_on == oe)
    else $error("power status differs from line release");
  a_connect_first: assert property ((oe & ~$past(oe) & ~$past(port_connect_detect)) == '0)
    else $error("line released without connection");
  a_unused_off: assert property ((oe & $past(port_unused)) == '0)
    else $error("unused port released");
  a_rail_follow: assert property ($past(arst_n) |-> pullup_rail_en == ~$past(port_unused))
    else $error("rail enable wrong");
  // fault capture
  a_flag_sticky: assert property ((~fl & $past(fl) & ~$past(overcurrent_clear)) == '0)
    else $error("flag dropped without clear");
  a_event_flag: assert property ((ev & ~fl) == '0)
    else $error("event without flag");
  a_event_on: assert property ((ev & ~$past(port_power_on)) == '0)
    else $error("event on port not powered");
  a_event_pulse: assert property ((ev & $past(ev)) == '0)
    else $error("event longer than one cycle");
  // role
  a_role_off: assert property ($past(role_is_device) |-> !oe[uppoc_pkg::DUAL_ROLE_PORT])
    else $error("dual-role port powered in device role");
  a_host_role: assert property (host_power_present |-> role_is_device)
    else $error("host power outside device role");

  // main scenarios
  c_power_on: cover property (port_power_on == '1);
  c_fault: cover property (ev != '0);
  c_role: cover property (host_power_present);
endmodule

bind uppoc_top uppoc_sva #(.NUM_PORTS(NUM_PORTS)) u_sva (.*);

`default_nettype wire

// ### verif/uppoc_sw_model.sv
`default_nettype none

// carrier power switch per port, enable and fault output tied to one line
module uppoc_sw_model #(
  parameter int unsigned N    = 5,
  parameter int unsigned HOLD = 3
) (
  // clock
  input  wire logic         clk,
  // module driver enable and fault injection
  input  wire logic [N-1:0] oe_n,
  input  wire logic [N-1:0] fault_req,
  // resolved line
  output logic      [N-1:0] line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [N-1:0] sink_q = '0;
  int           cnt [N];

  // wired-and of open drains, the only pull-up sits on the module side
  assign line = oe_n & ~sink_q;

  // on fault the switch sinks the line, disabling itself, then lets go
  always @(posedge clk) begin
    for (int i = 0; i < N; i++) begin
      if (fault_req[i] && line[i]) begin
        sink_q[i] <= 1'b1;
        cnt[i] <= HOLD;
      end else if (cnt[i] > 0) begin
        cnt[i] <= cnt[i] - 1;
      end else begin
        sink_q[i] <= 1'b0;
      end
    end
  end
endmodule

`default_nettype wire

// ### verif/usb_port_power_enable_overcurrent_tb.sv
`default_nettype none

module usb_port_power_enable_overcurrent_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int N = 5;

  // design inputs and fault injection
  logic           core_clk = 1'b0;
  logic           arst_n = 1'b0;
  logic [N-1:0]   port_power_request = '0;
  logic [N-1:0]   port_unused = '0;
  logic [N-1:0]   overcurrent_clear = '0;
  logic [N-1:0]   port_connect_detect = '0;
  logic           host_power_detect = 1'b0;
  logic           dual_role_id_input = 1'b0;
  logic [N-1:0]   fault_req = '0;
  // design outputs and the resolved line
  logic [N-1:0]   port_power_enable_fault_n_i;
  logic [N-1:0]   port_power_enable_fault_n_o;
  logic [N-1:0]   port_power_enable_fault_n_oe_n;
  logic [N-1:0]   pullup_rail_en;
  logic [N-1:0]   port_power_on;
  logic [N-1:0]   port_power_good;
  logic [N-1:0]   overcurrent_flag;
  logic [N-1:0]   overcurrent_event;
  logic [N*8-1:0] overcurrent_count;
  logic           role_is_device;
  logic           host_power_present;
  // bench model and bookkeeping
  int             exp_cnt [N];
  logic [N-1:0]   exp_flag = '0;
  logic [31:0]    seed = 32'hdc107e85;
  int             error_cnt = 0;
  int             cmp_count = 0;

  uppoc_top u_dut (.*);
  uppoc_sw_model #(.N(N)) u_sw (
    .clk      (core_clk),
    .oe_n     (port_power_enable_fault_n_oe_n),
    .fault_req(fault_req),
    .line     (port_power_enable_fault_n_i)
  );

  // 100 MHz clock
  always #5 core_clk = ~core_clk;

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("compares %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // one fault on a powered port, then clear and power up again
  task automatic hit(input int p);
    int k;
    @(posedge core_clk) fault_req[p] <= 1'b1;
    @(posedge core_clk) fault_req[p] <= 1'b0;
    for (k = 0; k < 30 && overcurrent_event[p] !== 1'b1; k++) @(negedge core_clk);
    if (k == 30) begin
      error_cnt++;
      summarize();
    end
    exp_cnt[p]++;
    exp_flag[p] = 1'b1;
    chk(overcurrent_flag, exp_flag);
    chk(overcurrent_count[8*p +: 8], exp_cnt[p]);
    chk(overcurrent_event, 32'h1 << p);
    cyc(1);
    chk(overcurrent_event, 32'h0);
    cyc(19);
    chk(overcurrent_flag, exp_flag);
    chk(port_power_enable_fault_n_oe_n, ~(32'h1 << p) & 32'h1f);
    @(posedge core_clk) begin
      overcurrent_clear[p] <= 1'b1;
      port_power_request[p] <= 1'b0;
    end
    @(posedge core_clk) begin
      overcurrent_clear[p] <= 1'b0;
      port_power_request[p] <= 1'b1;
    end
    exp_flag[p] = 1'b0;
    cyc(20);
    chk(overcurrent_flag, exp_flag);
    chk(port_power_enable_fault_n_oe_n, 5'h1f);
  endtask

  // main sequence
  initial begin
    repeat (16) @(posedge core_clk);
    chk(port_power_enable_fault_n_oe_n, 5'h00);
    arst_n <= 1'b1;
    @(posedge core_clk) port_power_request <= '1;
    cyc(10);
    chk(port_power_enable_fault_n_oe_n, 5'h00);
    chk(pullup_rail_en, 5'h1f);
    @(posedge core_clk) port_connect_detect <= '1;
    cyc(4);
    chk(port_power_enable_fault_n_oe_n, 5'h1f);
    chk(port_power_enable_fault_n_i, 5'h1f);
    cyc(12);
    chk(port_power_on, 5'h1f);
    chk(port_power_good, 5'h1f);
    for (int i = 0; i < 6; i++) begin
      seed = lfsr_next(seed);
      hit(int'(seed % N));
    end
    chk(port_power_on, 5'h1f);
    @(posedge core_clk) port_unused <= 5'h02;
    cyc(3);
    chk(port_power_enable_fault_n_oe_n, 5'h1d);
    chk(pullup_rail_en, 5'h1d);
    cyc(8);
    chk(overcurrent_flag, 5'h00);
    chk(overcurrent_count[15:8], exp_cnt[1]);
    @(posedge core_clk) begin
      host_power_detect <= 1'b1;
      dual_role_id_input <= 1'b1;
    end
    cyc(10);
    chk(role_is_device, 1);
    chk(host_power_present, 1);
    chk(port_power_enable_fault_n_oe_n, 5'h1c);
    @(posedge core_clk) dual_role_id_input <= 1'b0;
    cyc(10);
    chk(host_power_present, 0);
    chk(role_is_device, 0);
    chk(port_power_enable_fault_n_oe_n, 5'h1d);
    chk(overcurrent_flag, 5'h00);
    summarize();
  end
endmodule

`default_nettype wire
